// [src/rsq_regs.svh]
// constants of the reset and stop recovery sequencer
`ifndef RSQ_REGS_SVH
`define RSQ_REGS_SVH
// stretch counts in internal oscillator cycles
`define RSQ_CNT_STD 13'h0042
`define RSQ_CNT_XTAL 13'h1388
`define RSQ_CNT_W 13
// reset vector location in program memory
`define RSQ_VEC_HI_ADDR 16'h0002
`define RSQ_VEC_LO_ADDR 16'h0003
// general purpose port pins, shared reset pin index
`define RSQ_PORT_W 23
`define RSQ_SHARED_BIT 22
// system clock select codes
`define RSQ_CLK_IPO 2'h0
`define RSQ_CLK_W 2
`endif

// [src/rsq_pkg.sv]
// types of the reset and stop recovery sequencer
package rsq_pkg;
  typedef enum logic [2:0] {
    ST_WAIT_SUPPLY,
    ST_COUNT,
    ST_PIN_HOLD,
    ST_FETCH_HI,
    ST_FETCH_LO,
    ST_RUN
  } rsq_state_t;
  typedef enum logic {
    KIND_SYSTEM,
    KIND_STOP_RECOVERY
  } rsq_kind_t;
endpackage

// [src/rsq_sequencer.sv]
// reset and stop mode recovery sequencer, clocked by the internal oscillator
`timescale 1ns/1ps
`include "rsq_regs.svh"

//////////////////////////////////////////////////////////////////////////////
// Function
// [RULE_01] hold reset 66 oscillator cycles
// [RULE_02] crystal option stretches hold to 5000
// [RULE_03] power reset counts after supply good
// [RULE_04] stay in reset while pin held
// [RULE_05] pin low resets; device drives pin
// [RULE_06] stop recovery resets only watchdog, oscillator
// [RULE_07] ports become inputs, pull-ups off
// [RULE_08] shared pin is open-drain reset until reconfigured
// [RULE_09] core idle, oscillators keep running
// [RULE_10] registers with reset values get loaded
// [RULE_11] fetch vector 0002/0003 into program counter
// [RULE_12] reset selects internal oscillator as clock
// [RULE_13] counts are parameters, restart on new source
module rsq_sequencer #(
  parameter logic [`RSQ_CNT_W-1:0] CNT_STD = `RSQ_CNT_STD,
  parameter logic [`RSQ_CNT_W-1:0] CNT_XTAL = `RSQ_CNT_XTAL
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic supply_ok_i,
  input wire logic stop_recover_i,
  input wire logic xtal_opt_en_i,
  input wire logic rst_pin_i,
  output logic rst_pin_o,
  output logic rst_pin_oe_n_o,
  input wire logic pin_gpio_cfg_wr_i,
  input wire logic pin_gpio_data_i,
  input wire logic osc_sel_wr_i,
  input wire logic [`RSQ_CLK_W-1:0] osc_sel_i,
  output logic [`RSQ_CLK_W-1:0] sysclk_sel_o,
  output logic cpu_rst_o,
  output logic periph_idle_o,
  output logic ctl_reg_rst_o,
  output logic wdt_osc_reg_rst_o,
  output logic xtal_osc_run_o,
  output logic wdt_osc_run_o,
  output logic [`RSQ_PORT_W-1:0] port_force_in_o,
  output logic [`RSQ_PORT_W-1:0] port_pullup_off_o,
  output logic shared_pin_is_reset_o,
  output logic fetch_req_o,
  output logic [15:0] fetch_addr_o,
  input wire logic fetch_ack_i,
  input wire logic [7:0] fetch_data_i,
  output logic pc_load_o,
  output logic [15:0] pc_o
);

  rsq_pkg::rsq_state_t state_ff;
  rsq_pkg::rsq_state_t nxt_state;
  rsq_pkg::rsq_kind_t kind_ff;
  logic [2:0] pin_sync_ff;
  logic pin_lvl_ff;
  logic [2:0] sup_sync_ff;
  logic sup_lvl_ff;
  logic [`RSQ_CNT_W-1:0] cnt_ff;
  logic [`RSQ_CNT_W-1:0] cnt_lim_ff;
  logic pin_is_reset_ff;
  logic [`RSQ_CLK_W-1:0] clk_sel_ff;
  logic [7:0] vec_hi_ff;
  logic [15:0] pc_ff;
  logic pc_load_ff;
  logic [15:0] fetch_addr_ff;
  logic in_reset;
  logic pin_reset_req;
  logic restart;
  logic cnt_done;

  //////////////////////////////////////////////////////////////////////////////
  // pin and supply synchronisers; a level counts once stages two and three agree

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_sync_ff <= 3'h7;
      pin_lvl_ff <= 1'b1;
    end else begin
      pin_sync_ff <= {pin_sync_ff[1:0], rst_pin_i};
      if (pin_sync_ff[1] == pin_sync_ff[2]) begin
        pin_lvl_ff <= pin_sync_ff[2];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sup_sync_ff <= 3'h0;
      sup_lvl_ff <= 1'b0;
    end else begin
      sup_sync_ff <= {sup_sync_ff[1:0], supply_ok_i};
      if (sup_sync_ff[1] == sup_sync_ff[2]) begin
        sup_lvl_ff <= sup_sync_ff[2];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // reset sources

  // own drive keeps the pin low while waiting for supply and counting, so a low pin only requests a reset when running
  assign pin_reset_req = pin_is_reset_ff && !pin_lvl_ff &&
                         (state_ff == rsq_pkg::ST_RUN); // RULE_05
  assign restart = pin_reset_req || stop_recover_i; // RULE_13
  assign in_reset = (state_ff != rsq_pkg::ST_RUN);
  assign cnt_done = (cnt_ff >= cnt_lim_ff - `RSQ_CNT_W'(1));

  //////////////////////////////////////////////////////////////////////////////
  // sequence

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      rsq_pkg::ST_WAIT_SUPPLY: begin
        if (sup_lvl_ff) begin
          nxt_state = rsq_pkg::ST_COUNT; // RULE_03
        end
      end
      rsq_pkg::ST_COUNT: begin
        if (cnt_done) begin
          nxt_state = rsq_pkg::ST_PIN_HOLD; // RULE_01
        end
      end
      rsq_pkg::ST_PIN_HOLD: begin
        if (pin_lvl_ff || !pin_is_reset_ff) begin
          nxt_state = rsq_pkg::ST_FETCH_HI; // RULE_04
        end
      end
      rsq_pkg::ST_FETCH_HI: begin
        if (fetch_ack_i) begin
          nxt_state = rsq_pkg::ST_FETCH_LO;
        end
      end
      rsq_pkg::ST_FETCH_LO: begin
        if (fetch_ack_i) begin
          nxt_state = rsq_pkg::ST_RUN; // RULE_11
        end
      end
      rsq_pkg::ST_RUN: begin
        nxt_state = rsq_pkg::ST_RUN;
      end
      default: begin
        nxt_state = rsq_pkg::ST_WAIT_SUPPLY;
      end
    endcase
    // a supply drop is a power reset and always wins
    if (!sup_lvl_ff) begin
      nxt_state = rsq_pkg::ST_WAIT_SUPPLY; // RULE_03
    end else if (restart) begin
      nxt_state = rsq_pkg::ST_COUNT; // RULE_13
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= rsq_pkg::ST_WAIT_SUPPLY;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // kind of the reset in progress decides which registers are touched
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      kind_ff <= rsq_pkg::KIND_SYSTEM;
    end else if (!sup_lvl_ff || pin_reset_req) begin
      kind_ff <= rsq_pkg::KIND_SYSTEM;
    end else if (stop_recover_i && state_ff == rsq_pkg::ST_RUN) begin
      kind_ff <= rsq_pkg::KIND_STOP_RECOVERY; // RULE_06
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // stretch counter
  // limit must exceed the pin synchroniser lag, or a stale high pin level passes

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= '0;
    end else if (state_ff != rsq_pkg::ST_COUNT || restart) begin
      cnt_ff <= '0; // RULE_13
    end else if (!cnt_done) begin
      cnt_ff <= cnt_ff + `RSQ_CNT_W'(1); // RULE_01
    end
  end

  // option bit read while not counting so the limit is stable over a count
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_lim_ff <= CNT_STD;
    end else if (state_ff != rsq_pkg::ST_COUNT || restart) begin
      cnt_lim_ff <= xtal_opt_en_i ? CNT_XTAL : CNT_STD; // RULE_02
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // shared pin and port configuration

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_is_reset_ff <= 1'b1;
    end else if (in_reset || restart) begin
      pin_is_reset_ff <= 1'b1; // RULE_08
    end else if (pin_gpio_cfg_wr_i) begin
      pin_is_reset_ff <= 1'b0; // RULE_08
    end
  end

  // driven low in counting; released to let an outside hold show
  always_comb begin
    if (pin_is_reset_ff) begin
      rst_pin_o = 1'b0;
      rst_pin_oe_n_o = !(state_ff == rsq_pkg::ST_WAIT_SUPPLY ||
                         state_ff == rsq_pkg::ST_COUNT); // RULE_05
    end else begin
      rst_pin_o = pin_gpio_data_i;
      rst_pin_oe_n_o = 1'b0; // RULE_08
    end
  end

  assign shared_pin_is_reset_o = pin_is_reset_ff;

  // shared pin excluded from the input and pull-up forcing
  always_comb begin
    port_force_in_o = {`RSQ_PORT_W{in_reset}}; // RULE_07
    port_force_in_o[`RSQ_SHARED_BIT] = 1'b0; // RULE_07
    port_pullup_off_o = {`RSQ_PORT_W{in_reset}}; // RULE_07
    port_pullup_off_o[`RSQ_SHARED_BIT] = 1'b0; // RULE_07
  end

  //////////////////////////////////////////////////////////////////////////////
  // core, peripherals, registers and clocks

  assign cpu_rst_o = in_reset; // RULE_09
  assign periph_idle_o = in_reset; // RULE_09
  assign ctl_reg_rst_o = in_reset && (kind_ff == rsq_pkg::KIND_SYSTEM); // RULE_10
  assign wdt_osc_reg_rst_o = in_reset; // RULE_06
  // oscillators are not gated by reset; the crystal one follows its own option, the watchdog one always runs
  assign xtal_osc_run_o = xtal_opt_en_i; // RULE_09
  assign wdt_osc_run_o = 1'b1; // RULE_09

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_sel_ff <= `RSQ_CLK_IPO;
    end else if (in_reset) begin
      clk_sel_ff <= `RSQ_CLK_IPO; // RULE_12
    end else if (osc_sel_wr_i) begin
      clk_sel_ff <= osc_sel_i; // RULE_12
    end
  end

  assign sysclk_sel_o = clk_sel_ff;

  //////////////////////////////////////////////////////////////////////////////
  // reset vector fetch
  // no timeout: a memory that never answers keeps the core in reset

  assign fetch_req_o = (state_ff == rsq_pkg::ST_FETCH_HI) ||
                       (state_ff == rsq_pkg::ST_FETCH_LO);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fetch_addr_ff <= `RSQ_VEC_HI_ADDR;
    end else if (nxt_state == rsq_pkg::ST_FETCH_LO) begin
      fetch_addr_ff <= `RSQ_VEC_LO_ADDR; // RULE_11
    end else begin
      fetch_addr_ff <= `RSQ_VEC_HI_ADDR; // RULE_11
    end
  end

  assign fetch_addr_o = fetch_addr_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vec_hi_ff <= 8'h00;
    end else if (state_ff == rsq_pkg::ST_FETCH_HI && fetch_ack_i) begin
      vec_hi_ff <= fetch_data_i; // RULE_11
    end
  end

  // high byte at the lower address, then low byte
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_ff <= 16'h0000;
      pc_load_ff <= 1'b0;
    end else begin
      pc_load_ff <= 1'b0;
      if (state_ff == rsq_pkg::ST_FETCH_LO && fetch_ack_i && nxt_state == rsq_pkg::ST_RUN) begin
        pc_ff <= {vec_hi_ff, fetch_data_i}; // RULE_11
        pc_load_ff <= 1'b1; // RULE_11
      end
    end
  end

  assign pc_o = pc_ff;
  assign pc_load_o = pc_load_ff;

endmodule

// [tb/rsq_partner.sv]
// external supervisor on the open-drain reset line
`timescale 1ns/1ps
module rsq_partner (
  input wire logic hold_low_i,
  input wire logic drv_o_i,
  input wire logic drv_oe_n_i,
  output logic line_o
);
  // pull-up wins unless a party sinks; a driven high never beats a low
  assign line_o = !(hold_low_i || (!drv_oe_n_i && !drv_o_i));
endmodule

// [tb/rsq_checker.sv]
// assertions on the reset sequencer ports
`timescale 1ns/1ps
`include "rsq_regs.svh"
module rsq_checker #(
  parameter logic [`RSQ_CNT_W-1:0] CNT_STD = `RSQ_CNT_STD,
  parameter logic [`RSQ_CNT_W-1:0] CNT_XTAL = `RSQ_CNT_XTAL
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic supply_ok_i,
  input wire logic stop_recover_i,
  input wire logic xtal_opt_en_i,
  input wire logic rst_pin_i,
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe_n_o,
  input wire logic [`RSQ_CLK_W-1:0] sysclk_sel_o,
  input wire logic cpu_rst_o,
  input wire logic ctl_reg_rst_o,
  input wire logic [`RSQ_PORT_W-1:0] port_force_in_o,
  input wire logic shared_pin_is_reset_o,
  input wire logic fetch_req_o,
  input wire logic [15:0] fetch_addr_o,
  input wire logic fetch_ack_i,
  input wire logic [7:0] fetch_data_i,
  input wire logic pc_load_o,
  input wire logic [15:0] pc_o
);
  logic [15:0] cnt_ff;
  logic [15:0] exp_ff;
  logic smr_ff;
  logic [7:0] hi_ff;
  logic [7:0] lo_ff;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////
  // own drive cycles since the last stop pulse; a new pulse restarts it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= 16'h0000;
      exp_ff <= 16'h0000;
      smr_ff <= 1'b0;
    end else if (stop_recover_i) begin
      cnt_ff <= 16'h0000;
      exp_ff <= 16'(xtal_opt_en_i ? CNT_XTAL : CNT_STD);
      smr_ff <= smr_ff || !cpu_rst_o;
    end else begin
      cnt_ff <= cnt_ff + 16'(!rst_pin_oe_n_o);
      smr_ff <= smr_ff && !pc_load_o && supply_ok_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (fetch_req_o && fetch_ack_i && fetch_addr_o == `RSQ_VEC_HI_ADDR) hi_ff <= fetch_data_i;
    if (fetch_req_o && fetch_ack_i && fetch_addr_o == `RSQ_VEC_LO_ADDR) lo_ff <= fetch_data_i;
  end
  ////////////////////////////////////////
  pin_drive_a: assert property (
    !rst_pin_oe_n_o && shared_pin_is_reset_o |-> cpu_rst_o && !rst_pin_o)
    else $error("pin driven outside reset");
  clk_ipo_a: assert property (
    $past(cpu_rst_o) && cpu_rst_o |-> sysclk_sel_o == `RSQ_CLK_IPO)
    else $error("clock not internal in reset");
  port_in_a: assert property (
    cpu_rst_o |-> port_force_in_o == {1'b0, {`RSQ_SHARED_BIT{1'b1}}})
    else $error("ports not forced in");
  fetch_seq_a: assert property (
    fetch_req_o && fetch_ack_i && fetch_addr_o == `RSQ_VEC_HI_ADDR
    |=> fetch_req_o && fetch_addr_o == `RSQ_VEC_LO_ADDR)
    else $error("low byte not fetched next");
  pc_vec_a: assert property (
    pc_load_o |-> pc_o == {hi_ff, lo_ff} && !cpu_rst_o)
    else $error("pc not the fetched vector");
  hold_pin_a: assert property (
    (cpu_rst_o && !fetch_req_o && !rst_pin_i) [*4] |=> !fetch_req_o)
    else $error("left reset with pin low");
  stop_keep_a: assert property (
    smr_ff && cpu_rst_o |-> !ctl_reg_rst_o)
    else $error("stop recovery reset registers");
  stretch_len_a: assert property (
    smr_ff && $rose(rst_pin_oe_n_o) |-> cnt_ff == exp_ff)
    else $error("stretch length wrong");
endmodule
bind rsq_sequencer rsq_checker #(.CNT_STD(CNT_STD), .CNT_XTAL(CNT_XTAL)) chk (
  .clk_i, .rst_n_i, .supply_ok_i, .stop_recover_i, .xtal_opt_en_i, .rst_pin_i, .rst_pin_o,
  .rst_pin_oe_n_o, .sysclk_sel_o, .cpu_rst_o, .ctl_reg_rst_o, .port_force_in_o,
  .shared_pin_is_reset_o, .fetch_req_o, .fetch_addr_o, .fetch_ack_i, .fetch_data_i,
  .pc_load_o, .pc_o);

// [tb/tb_rsq_sequencer.sv]
// self-checking bench of the reset sequencer
`timescale 1ns/1ps
`include "rsq_regs.svh"
`define CK(n, e, s) begin compares++; if ((s) !== (e)) begin errors++; \
  $display("Error %s exp %h got %h", n, e, s); end end
module tb_rsq_sequencer;
  localparam int CS = 8;
  localparam int CX = 20;
  localparam logic [15:0] VEC = 16'hC3A5;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic supply_ok_i = 1'b0;
  logic stop_recover_i = 1'b0;
  logic xtal_opt_en_i = 1'b0;
  logic ext_low = 1'b0;
  logic pin_gpio_cfg_wr_i = 1'b0;
  logic pin_gpio_data_i = 1'b0;
  logic osc_sel_wr_i = 1'b0;
  logic [1:0] osc_sel_i = 2'h0;
  logic fetch_ack_i = 1'b0;
  logic [7:0] fetch_data_i = 8'h00;
  logic rst_pin_i, rst_pin_o, rst_pin_oe_n_o, cpu_rst_o, ctl_reg_rst_o, xtal_osc_run_o;
  logic wdt_osc_run_o, shared_pin_is_reset_o, fetch_req_o, pc_load_o;
  logic periph_idle_o, wdt_osc_reg_rst_o;
  logic [1:0] sysclk_sel_o;
  logic [22:0] port_force_in_o;
  logic [22:0] port_pullup_off_o;
  logic [6:0] rel_st;
  logic [5:0] run_st;
  logic [15:0] fetch_addr_o, pc_o;
  int errors = 0;
  int compares = 0;
  int mem_dly = 3;
  int wt = 0;
  initial forever #10 clk_i = ~clk_i;
  rsq_partner ext (.hold_low_i(ext_low), .drv_o_i(rst_pin_o), .drv_oe_n_i(rst_pin_oe_n_o),
    .line_o(rst_pin_i));
  rsq_sequencer #(.CNT_STD(13'h0008), .CNT_XTAL(13'h0014)) dut (
    .clk_i, .rst_n_i, .supply_ok_i, .stop_recover_i, .xtal_opt_en_i, .rst_pin_i, .rst_pin_o,
    .rst_pin_oe_n_o, .pin_gpio_cfg_wr_i, .pin_gpio_data_i, .osc_sel_wr_i, .osc_sel_i,
    .sysclk_sel_o, .cpu_rst_o, .periph_idle_o, .ctl_reg_rst_o, .wdt_osc_reg_rst_o,
    .xtal_osc_run_o, .wdt_osc_run_o, .port_force_in_o, .port_pullup_off_o,
    .shared_pin_is_reset_o, .fetch_req_o, .fetch_addr_o, .fetch_ack_i, .fetch_data_i,
    .pc_load_o, .pc_o);
  // grouped status for compact compares
  assign rel_st = {cpu_rst_o, periph_idle_o, wdt_osc_reg_rst_o, ctl_reg_rst_o, sysclk_sel_o,
    shared_pin_is_reset_o};
  assign run_st = {sysclk_sel_o, shared_pin_is_reset_o, xtal_osc_run_o, rst_pin_o,
    rst_pin_oe_n_o};
  ////////////////////////////////////////
  // vector memory; idle data toggles so a stale byte cannot pass
  always @(negedge clk_i) begin
    if (fetch_ack_i || !fetch_req_o) begin
      fetch_ack_i <= 1'b0;
      fetch_data_i <= ~fetch_data_i;
      wt <= 0;
    end else if (wt >= mem_dly) begin
      fetch_ack_i <= 1'b1;
      fetch_data_i <= fetch_addr_o == `RSQ_VEC_HI_ADDR ? VEC[15:8] : VEC[7:0];
    end else begin
      wt <= wt + 1;
    end
  end
  task automatic run(input int lo, input int hi);
    int n;
    n = 0;
    while (!rst_pin_oe_n_o && n < 9000) begin
      `CK("ports", {2{1'b0, {22{1'b1}}}}, {port_force_in_o, port_pullup_off_o})
      n++;
      @(negedge clk_i);
    end
    `CK("stretch", 1'b1, n >= lo && n <= hi)
    repeat (60) if (!pc_load_o) @(negedge clk_i);
    `CK("boot", {1'b1, VEC}, {pc_load_o, pc_o})
    `CK("released", 7'h01, rel_st)
  endtask
  task automatic t_stop(input logic x, input int c);
    xtal_opt_en_i = x;
    pin_gpio_data_i = 1'b1;
    pin_gpio_cfg_wr_i = 1'b1;
    osc_sel_wr_i = 1'b1;
    osc_sel_i = 2'h1;
    @(negedge clk_i);
    pin_gpio_cfg_wr_i = 1'b0;
    osc_sel_wr_i = 1'b0;
    @(negedge clk_i);
    `CK("run", {3'h2, x, 2'h2}, run_st)
    stop_recover_i = 1'b1;
    @(negedge clk_i);
    stop_recover_i = 1'b0;
    `CK("regs kept", 3'h3, {ctl_reg_rst_o, wdt_osc_reg_rst_o, periph_idle_o})
    repeat (2) @(negedge clk_i);
    stop_recover_i = 1'b1;
    @(negedge clk_i);
    stop_recover_i = 1'b0;
    run(c, c);
  endtask
  task automatic conclude();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // supply low for w cycles, then a power reset count of lo to hi cycles
  task automatic t_supply(input int w, input int lo, input int hi);
    supply_ok_i = 1'b0;
    repeat (w) @(negedge clk_i);
    `CK("wait", 4'hF, {cpu_rst_o, !rst_pin_i, ctl_reg_rst_o, wdt_osc_run_o})
    supply_ok_i = 1'b1;
    @(negedge clk_i);
    run(lo, hi);
  endtask
  task automatic t_pin_hold();
    mem_dly = 0;
    ext_low = 1'b1;
    repeat (CX + 30) @(negedge clk_i);
    `CK("hold", 3'h7, {cpu_rst_o, ctl_reg_rst_o, rst_pin_oe_n_o})
    ext_low = 1'b0;
    run(0, 0);
  endtask
  initial begin
    repeat (3) @(negedge clk_i);
    rst_n_i = 1'b1;
    t_supply(20, CS + 1, CS + 6);
    t_stop(1'b0, CS);
    t_stop(1'b1, CX);
    t_pin_hold();
    // crystal option still set: the power reset stretches to the long count
    t_supply(6, CX + 1, CX + 6);
    conclude();
  end
  // generous bound: the whole sequence needs well under a thousand cycles
  initial begin
    #60000;
    errors++;
    conclude();
  end
endmodule
